// File: rtl/led_status_defines.vh
`ifndef LED_STATUS_DEFINES_VH
`define LED_STATUS_DEFINES_VH

// ----------------------------------------------------------------
// display modes
// ----------------------------------------------------------------
`define MODE_0            2'h0
`define MODE_1            2'h1
`define MODE_2            2'h2
`define MODE_3            2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     25
`define RESET_HOLD_US     1000
`define RESET_HOLD_CYC    ((`RESET_HOLD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PHASE_DEFAULT     16
`define FRAME_PHASES      4'h8

// ----------------------------------------------------------------
// axi-lite register map
// ----------------------------------------------------------------
`define ADDR_STATUS       4'h0
`define ADDR_ENABLE       4'h4
`define ADDR_CLEAR        4'h8
`define ADDR_MODE         4'hC
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define ST_COLLISION      0
`define ST_JABBER         1
`define ST_FIFO_ERR       2
`define ST_PARTITION      3
`define ST_WIDTH          4

`endif

// File: rtl/repeater_led_status_driver.v
// Contract
// - seven indicator drivers: four twisted-pair, one attachment, two common.
// - each indicator is three-level: driven high, released, or driven low.
// - floating straps read low; both low selects mode 0.
// - mode number is upper strap then lower strap.
// - mode 0: link, tx, polarity, rx, partition; common fifo error, collision.
// - mode 1: link and rx; attachment rx only; common jabber, collision.
// - mode 2: link, partition, rx; attachment partition, rx; common jabber, collision.
// - mode 3: link, rx, partition; attachment rx, partition; common jabber, collision.
// - straps sampled at reset; reset held over 1 ms to latch them.
`timescale 1ns/100ps
`default_nettype none
`include "led_status_defines.vh"

module repeater_led_status_driver #(
    parameter integer RESET_HOLD_CYC = `RESET_HOLD_CYC,
    parameter integer PHASE_CYC      = `PHASE_DEFAULT
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        display_select_upper,
    input  wire        display_select_lower,
    input  wire [3:0]  tp_link_pulse,
    input  wire [3:0]  tp_tx_packet,
    input  wire [3:0]  tp_rev_polarity,
    input  wire [3:0]  tp_rx_packet,
    input  wire [3:0]  tp_partitioned,
    input  wire        aui_tx_packet,
    input  wire        aui_rx_packet,
    input  wire        aui_partitioned,
    input  wire        fifo_error,
    input  wire        collision,
    input  wire        jabber_lockup_protection,
    output reg  [3:0]  twisted_pair_port_indicator_o,
    output reg  [3:0]  twisted_pair_port_indicator_oe,
    output reg         attachment_port_indicator_o,
    output reg         attachment_port_indicator_oe,
    output reg  [1:0]  common_function_indicator_o,
    output reg  [1:0]  common_function_indicator_oe,
    output reg         irq,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

// ----------------------------------------------------------------
// pattern encodings (drive high, drive low, release)
// ----------------------------------------------------------------
localparam [1:0] PH_Z  = 2'h0;
localparam [1:0] PH_HI = 2'h1;
localparam [1:0] PH_LO = 2'h2;

reg  [1:0]  mode_reg;
reg  [31:0] hold_cnt_reg;
reg  [31:0] phase_cnt_reg;
reg  [2:0]  frame_reg;
reg  [3:0]  status_reg;
reg  [3:0]  enable_reg;
reg  [3:0]  aw_addr_reg;
reg         aw_have_reg;
reg  [31:0] w_data_reg;
reg         w_have_reg;

// ----------------------------------------------------------------
// condition pattern: each condition owns its phase sequence
// ----------------------------------------------------------------
function [1:0] pattern;
    input [2:0] cond;
    input [2:0] slot;
    begin
        case (cond)
            3'h1:    pattern = (slot < 3'h4) ? PH_HI : PH_Z;
            3'h2:    pattern = (slot < 3'h4) ? PH_LO : PH_Z;
            3'h3:    pattern = slot[0] ? PH_LO : PH_HI;
            3'h4:    pattern = slot[1] ? PH_HI : PH_Z;
            3'h5:    pattern = slot[1] ? PH_LO : PH_Z;
            default: pattern = PH_Z;
        endcase
    end
endfunction

// picks lowest-numbered active condition for a port pin
function [2:0] port_cond;
    input [1:0] mode;
    input       is_aui;
    input       link;
    input       tx;
    input       pol;
    input       rx;
    input       part;
    begin
        port_cond = 3'h0;
        case (mode)
            `MODE_0: begin
                if (part)
                    port_cond = 3'h5;
                if (rx)
                    port_cond = 3'h4;
                if (pol && !is_aui)
                    port_cond = 3'h3;
                if (tx)
                    port_cond = 3'h2;
                if (link && !is_aui)
                    port_cond = 3'h1;
            end
            `MODE_1: begin
                if (rx)
                    port_cond = 3'h4;
                if (link && !is_aui)
                    port_cond = 3'h1;
            end
            `MODE_2: begin
                if (rx)
                    port_cond = 3'h4;
                if (part)
                    port_cond = 3'h2;
                if (link && !is_aui)
                    port_cond = 3'h1;
            end
            `MODE_3: begin
                if (part)
                    port_cond = 3'h3;
                if (rx)
                    port_cond = 3'h2;
                if (link && !is_aui)
                    port_cond = 3'h1;
            end
            default: port_cond = 3'h0;
        endcase
    end
endfunction

function [2:0] common_cond;
    input [1:0] mode;
    input       fifo;
    input       coll;
    input       jab;
    begin
        common_cond = 3'h0;
        if (coll)
            common_cond = 3'h3;
        if ((mode == `MODE_0) ? fifo : jab)
            common_cond = 3'h1;
    end
endfunction

// ----------------------------------------------------------------
// strap capture while reset is held
// ----------------------------------------------------------------
// the mode register has no reset value: a reset too short to reach the
// hold count keeps the mode latched by the last long enough one
always @(posedge aclk) begin
    if (!aresetn) begin
        if (hold_cnt_reg < RESET_HOLD_CYC)
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
        else
            mode_reg <= {display_select_upper, display_select_lower};
    end else begin
        hold_cnt_reg <= 32'h0;
    end
end

// ----------------------------------------------------------------
// pattern timebase: PHASE_CYC cycles a slot, eight slots a frame
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        phase_cnt_reg <= 32'h0;
        frame_reg     <= 3'h0;
    end else if (phase_cnt_reg >= PHASE_CYC - 1) begin
        phase_cnt_reg <= 32'h0;
        frame_reg     <= frame_reg + 3'h1;
    end else begin
        phase_cnt_reg <= phase_cnt_reg + 32'h1;
    end
end

// ----------------------------------------------------------------
// pin phases from the latched mode
// ----------------------------------------------------------------
// level and enable that a pin shows for one phase code
function drive_hi;
    input [1:0] ph;
    begin
        drive_hi = (ph == PH_HI);
    end
endfunction

function drive_en;
    input [1:0] ph;
    begin
        drive_en = (ph != PH_Z);
    end
endfunction

integer   i;
reg [7:0] tp_ph_next;
reg [1:0] aui_ph_next;
reg [1:0] cf_ph_next;

always @* begin
    tp_ph_next = 8'h00;
    for (i = 0; i < 4; i = i + 1) begin
        tp_ph_next[2*i +: 2] = pattern(port_cond(mode_reg, 1'b0, tp_link_pulse[i],
                                                 tp_tx_packet[i], tp_rev_polarity[i],
                                                 tp_rx_packet[i], tp_partitioned[i]),
                                       frame_reg);
    end
    aui_ph_next = pattern(port_cond(mode_reg, 1'b1, 1'b0, aui_tx_packet, 1'b0,
                                    aui_rx_packet, aui_partitioned), frame_reg);
    cf_ph_next  = pattern(common_cond(mode_reg, fifo_error, collision,
                                      jabber_lockup_protection), frame_reg);
end

// ----------------------------------------------------------------
// indicator outputs
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        twisted_pair_port_indicator_o  <= 4'h0;
        twisted_pair_port_indicator_oe <= 4'h0;
        attachment_port_indicator_o    <= 1'b0;
        attachment_port_indicator_oe   <= 1'b0;
        common_function_indicator_o    <= 2'h0;
        common_function_indicator_oe   <= 2'h0;
    end else begin
        twisted_pair_port_indicator_o  <= {drive_hi(tp_ph_next[7:6]), drive_hi(tp_ph_next[5:4]),
                                           drive_hi(tp_ph_next[3:2]), drive_hi(tp_ph_next[1:0])};
        twisted_pair_port_indicator_oe <= {drive_en(tp_ph_next[7:6]), drive_en(tp_ph_next[5:4]),
                                           drive_en(tp_ph_next[3:2]), drive_en(tp_ph_next[1:0])};
        attachment_port_indicator_o    <= drive_hi(aui_ph_next);
        attachment_port_indicator_oe   <= drive_en(aui_ph_next);
        common_function_indicator_o    <= {2{drive_hi(cf_ph_next)}};
        common_function_indicator_oe   <= {2{drive_en(cf_ph_next)}};
    end
end

// ----------------------------------------------------------------
// event status, enable and interrupt
// ----------------------------------------------------------------
// an event is the level of its input; set wins over a clear in one cycle
reg [`ST_WIDTH-1:0] events;
always @* begin
    events = {`ST_WIDTH{1'b0}};
    events[`ST_COLLISION] = collision;
    events[`ST_JABBER]    = jabber_lockup_protection;
    events[`ST_FIFO_ERR]  = fifo_error;
    events[`ST_PARTITION] = (tp_partitioned != 4'h0) | aui_partitioned;
end

wire       wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
wire [3:0] clr_bits = (wr_fire && aw_addr_reg == `ADDR_CLEAR) ? w_data_reg[3:0] : 4'h0;

always @(posedge aclk) begin
    if (!aresetn) begin
        status_reg <= 4'h0;
        irq        <= 1'b0;
    end else begin
        status_reg <= (status_reg & ~clr_bits) | events;
        irq        <= (((status_reg & ~clr_bits) | events) & enable_reg) != 4'h0;
    end
end

// ----------------------------------------------------------------
// axi4-lite slave
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_addr_reg   <= 4'h0;
        aw_have_reg   <= 1'b0;
        w_data_reg    <= 32'h0;
        w_have_reg    <= 1'b0;
        enable_reg    <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `RESP_OKAY;
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h0;
        s_axi_rresp   <= `RESP_OKAY;
    end else begin
        // each ready pulses for one edge; the word lands once both halves are held
        s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
        s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
            aw_have_reg <= 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg <= s_axi_wdata;
            w_have_reg <= 1'b1;
        end
        if (wr_fire) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `RESP_OKAY;
            if (aw_addr_reg == `ADDR_ENABLE)
                enable_reg <= w_data_reg[3:0];
            else if (aw_addr_reg != `ADDR_CLEAR)
                s_axi_bresp <= `RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        // no new read address is taken while an answer still stands
        s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            case (s_axi_araddr)
                `ADDR_STATUS: s_axi_rdata <= {28'h0, status_reg};
                `ADDR_ENABLE: s_axi_rdata <= {28'h0, enable_reg};
                `ADDR_CLEAR:  s_axi_rdata <= 32'h0;
                `ADDR_MODE:   s_axi_rdata <= {30'h0, mode_reg};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

// File: verif/led_board.sv
`timescale 1ns/100ps
`default_nettype none
module led_board (
    input  wire logic       aclk,
    input  wire logic [6:0] drv_o,
    input  wire logic [6:0] drv_oe,
    output var  logic [6:0] lit_hi,
    output var  logic [6:0] lit_lo
);
    logic [6:0] last = 7'h00;
    // a released pin floats: show the inverse of its last level
    wire  [6:0] pin = drv_oe & drv_o | ~drv_oe & ~last;
    always @(posedge aclk) last <= pin;
    assign lit_hi = drv_oe & pin;
    assign lit_lo = drv_oe & ~pin;
endmodule
`default_nettype wire

// File: verif/led_status_checker.sv
`timescale 1ns/100ps
`default_nettype none
module led_status_checker (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic [3:0] tp_link_pulse,
    input wire logic       aui_tx_packet,
    input wire logic       aui_rx_packet,
    input wire logic       aui_partitioned,
    input wire logic       fifo_error,
    input wire logic       collision,
    input wire logic       jabber_lockup_protection,
    input wire logic [3:0] twisted_pair_port_indicator_o,
    input wire logic [3:0] twisted_pair_port_indicator_oe,
    input wire logic       attachment_port_indicator_oe,
    input wire logic [1:0] common_function_indicator_oe,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_cf_quiet; !(fifo_error || collision || jabber_lockup_protection); endsequence
    sequence s_aui_quiet; !(aui_tx_packet || aui_rx_packet || aui_partitioned); endsequence
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_rd_lat; s_ar_taken |=> s_axi_rvalid; endproperty
    property p_rd_cause; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready); endproperty
    property p_rd_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    property p_wr_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    property p_cf_idle; s_cf_quiet |=> common_function_indicator_oe == 2'h0; endproperty
    property p_aui_idle; s_aui_quiet |=> !attachment_port_indicator_oe; endproperty
    property p_cf_coll;
        (collision && !fifo_error && !jabber_lockup_protection) [*2]
            |=> common_function_indicator_oe == 2'h3;
    endproperty
    property p_tp_link;
        tp_link_pulse[0] [*2]
            |=> !twisted_pair_port_indicator_oe[0] || twisted_pair_port_indicator_o[0];
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    a_rd_cause: assert property (p_rd_cause) else $error("read answer without request");
    a_rd_once: assert property (p_rd_once) else $error("read answer repeated");
    a_wr_once: assert property (p_wr_once) else $error("write answer repeated");
    a_cf_idle: assert property (p_cf_idle) else $error("common pin driven idle");
    a_aui_idle: assert property (p_aui_idle) else $error("aui pin driven idle");
    a_cf_coll: assert property (p_cf_coll) else $error("collision not driven");
    a_tp_link: assert property (p_tp_link) else $error("link pin driven low");
endmodule
bind repeater_led_status_driver led_status_checker u_led_status_checker (.*);
`default_nettype wire

// File: verif/repeater_led_status_driver_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "led_status_defines.vh"
module repeater_led_status_driver_test;
    localparam int P = 2;
    logic aclk, aresetn, irq;
    logic [1:0] strap_drv;
    // board pull-downs: a strap left floating reads low
    tri0 display_select_upper, display_select_lower;
    assign display_select_upper = strap_drv[1];
    assign display_select_lower = strap_drv[0];
    logic [3:0] tp_link_pulse, tp_tx_packet, tp_rev_polarity, tp_rx_packet, tp_partitioned;
    logic aui_tx_packet, aui_rx_packet, aui_partitioned, fifo_error, collision;
    logic jabber_lockup_protection, attachment_port_indicator_o, attachment_port_indicator_oe;
    logic [3:0] twisted_pair_port_indicator_o, twisted_pair_port_indicator_oe;
    logic [1:0] common_function_indicator_o, common_function_indicator_oe;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bready, s_axi_bvalid;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, seed;
    logic [6:0] lit_hi, lit_lo;
    int bad_count, num_checks, cyc, mode;
    wire [6:0] all_o = {common_function_indicator_o, attachment_port_indicator_o,
                        twisted_pair_port_indicator_o};
    wire [6:0] all_oe = {common_function_indicator_oe, attachment_port_indicator_oe,
                         twisted_pair_port_indicator_oe};
    repeater_led_status_driver #(.RESET_HOLD_CYC(4), .PHASE_CYC(P)) u_repeater_led_status_driver (.*);
    led_board u_led_board (.aclk(aclk), .drv_o(all_o), .drv_oe(all_oe), .lit_hi(lit_hi), .lit_lo(lit_lo));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            print_verdict();
        end
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s exp %0h seen %0h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic apply(logic [31:0] x);
        tp_link_pulse <= x[3:0];
        tp_tx_packet <= x[7:4];
        tp_rev_polarity <= x[11:8];
        tp_rx_packet <= x[15:12];
        tp_partitioned <= x[19:16];
        {aui_partitioned, aui_rx_packet, aui_tx_packet} <= x[22:20];
        {jabber_lockup_protection, collision, fifo_error} <= x[25:23];
    endtask
    task automatic axi_wr(logic [3:0] a, logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
    // lowest active condition of one pin: 0..3 ports, 4 attachment, 5..6 common
    function automatic int exp_cond(int p);
        logic [5:1] a;
        int c = 0;
        logic tx = p < 4 ? tp_tx_packet[p % 4] : aui_tx_packet;
        logic rx = p < 4 ? tp_rx_packet[p % 4] : aui_rx_packet;
        logic pt = p < 4 ? tp_partitioned[p % 4] : aui_partitioned;
        logic ln = p < 4 && tp_link_pulse[p % 4];
        logic pl = p < 4 && tp_rev_polarity[p % 4];
        case (mode)
            0: a = {pt, rx, pl, tx, ln};
            1: a = {1'b0, rx, 2'b00, ln};
            2: a = {1'b0, rx, 1'b0, pt, ln};
            default: a = {2'b00, pt, rx, ln};
        endcase
        if (p > 4) a = {2'b00, collision, 1'b0, mode == 0 ? fifo_error : jabber_lockup_protection};
        for (int i = 5; i > 0; i--)
            if (a[i]) c = i;
        return c;
    endfunction
    // one frame per pin: count high, low and level changes
    task automatic measure();
        int hi[7] = '{7{0}};
        int lo[7] = '{7{0}};
        int tg[7] = '{7{0}};
        int c;
        logic [1:0] st, first[7], prev[7];
        repeat (3) @(posedge aclk);
        for (int k = 0; k < 8 * P; k++) begin
            @(negedge aclk);
            for (int j = 0; j < 7; j++) begin
                st = {lit_hi[j], lit_lo[j]};
                hi[j] += st[1];
                lo[j] += st[0];
                if (k == 0) first[j] = st;
                else tg[j] += int'(st != prev[j]);
                prev[j] = st;
            end
        end
        for (int j = 0; j < 7; j++) begin
            c = exp_cond(j);
            tg[j] += int'(prev[j] != first[j]);
            check("high", hi[j], (c == 1 || c == 3 || c == 4) ? 4 * P : 0);
            check("low", lo[j], (c == 2 || c == 3 || c == 5) ? 4 * P : 0);
            check("edges", tg[j], c == 0 ? 0 : (c == 3 ? 8 : (c > 3 ? 4 : 2)));
        end
        @(posedge aclk);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'h00016ABE;
        aresetn <= 1'b0;
        strap_drv <= 2'hZ;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {8'h00, 32'h0, 4'hF};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
        apply(32'h0);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            if (m > 0) begin
                @(posedge aclk);
                aresetn <= 1'b0;
                strap_drv <= m[1:0];
                repeat (5) @(posedge aclk);
                aresetn <= 1'b1;
                strap_drv <= ~m[1:0];
                mode = m;
            end
            axi_rd(`ADDR_MODE, rd, resp);
            check("mode", rd, m);
            axi_rd(`ADDR_ENABLE, rd, resp);
            check("enable", rd, 0);
            for (int v = 0; v < 6; v++) begin
                apply(v == 0 ? 32'h0 : rnd() & rnd());
                measure();
            end
            $display("mode %0d test done", m);
        end
        apply(32'h0);
        axi_wr(`ADDR_CLEAR, 32'hF, resp);
        apply(32'h01000000);
        repeat (2) @(posedge aclk);
        apply(32'h0);
        axi_rd(`ADDR_STATUS, rd, resp);
        check("status", rd, 1);
        check("irq masked", irq, 0);
        axi_wr(`ADDR_ENABLE, 32'h1, resp);
        repeat (2) @(posedge aclk);
        check("irq", irq, 1);
        axi_wr(`ADDR_CLEAR, 32'h1, resp);
        repeat (2) @(posedge aclk);
        check("irq cleared", irq, 0);
        axi_wr(`ADDR_STATUS, 32'h0, resp);
        check("ro write", resp, `RESP_SLVERR);
        axi_rd(4'h2, rd, resp);
        check("unmapped", resp, `RESP_SLVERR);
        $display("interrupt test done");
        print_verdict();
    end
endmodule
`default_nettype wire
